// file: core/spsf_pkg.sv
// Package of the serial-port status flag block: register map, field layout,
// reset values and the structs that carry control, link inputs and events.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package spsf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses within the block)
    localparam int unsigned      ADDR_W          = 4;
    localparam logic [3:0]       STATUS_OFS      = 4'h0;
    localparam logic [3:0]       CONTROL_OFS     = 4'h4;

    ////////////////////////////////////////////////////////////////////////////
    // Status word field positions
    localparam int unsigned      ST_EXCESS_BIT   = 11;
    localparam int unsigned      ST_RXFILL_LSB   = 8;
    localparam int unsigned      ST_OVF_BIT      = 7;
    localparam int unsigned      ST_RXIRQ_BIT    = 6;
    localparam int unsigned      ST_TXIRQ_BIT    = 5;
    localparam int unsigned      ST_UF_BIT       = 4;
    localparam int unsigned      ST_TXFILL_LSB   = 1;
    localparam int unsigned      ST_SUM_BIT      = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Control word field positions and reset value
    localparam int unsigned      CT_IRQMODE_LSB  = 0;
    localparam int unsigned      CT_RXTHR_LSB    = 2;
    localparam int unsigned      CT_DIR_BIT      = 4;
    localparam int unsigned      CT_RXFLUSH_BIT  = 5;
    localparam int unsigned      CT_TXFLUSH_BIT  = 6;
    localparam logic [6:0]       CONTROL_RESET   = 7'h00;

    ////////////////////////////////////////////////////////////////////////////
    // FIFO geometry
    localparam int unsigned      FILL_W          = 3;
    localparam logic [2:0]       FILL_FULL       = 3'h4;
    localparam logic [2:0]       FILL_EMPTY      = 3'h0;

    typedef struct packed {
        logic       tx_flush_control;
        logic       rx_flush_control;
        logic       transfer_direction_select;
        logic [1:0] rx_threshold_field;
        logic [1:0] irq_threshold_field;
    } spsf_ctrl_s;

    typedef struct packed {
        logic       rx_load;
        logic       tx_start;
        logic       tx_done;
        logic [2:0] rx_fill_count;
        logic [2:0] tx_fill_count;
    } spsf_link_s;

    typedef struct packed {
        logic ovf;
        logic uf;
        logic rx_irq;
        logic tx_irq;
    } spsf_evt_s;

    // Receive threshold in bytes: 00 and 01 need one, 10 three, 11 a full FIFO
    function automatic logic [2:0] rx_thr_bytes(input logic [1:0] code);
        logic [2:0] n;
        n = 3'h1;
        if (code == 2'h2) begin
            n = 3'h3;
        end else if (code == 2'h3) begin
            n = FILL_FULL;
        end
        return n;
    endfunction : rx_thr_bytes

    function automatic logic [2:0] bin2gray(input logic [2:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [2:0] gray2bin(input logic [2:0] g);
        return {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
    endfunction : gray2bin

endpackage : spsf_pkg

// file: core/spsf_sync.sv
// Two flip-flop level synchroniser of parameterised width.
// Assumes each bit is either quasi-static or gray coded in the source domain.
module spsf_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // No reset: the second stage settles within two edges of a running clock
    always_ff @(posedge clk_i) begin
        meta_q <= d_i;
        sync_q <= meta_q;
    end

    assign q_o = sync_q;

endmodule : spsf_sync

// file: core/spsf_top.sv
// Status-flag logic of a serial peripheral port: status and control words on
// classic Wishbone, event and fill-level capture on the serial link clock.
// Assumes the FIFO and shift logic drives link_i from the link clock domain.
//
// Functional notes
// RULE1: The excess flag at bit 11 is high while the receive fill exceeds the receive threshold.
// RULE2: Bits 10:8 show the receive FIFO fill as a binary count from 0 to 4.
// RULE3: Bit 7 sets when a byte is loaded into an already full receive FIFO.
// RULE4: A receive overflow raises the summary interrupt only while receive flush is clear.
// RULE5: Bit 6 sets on reaching the receive threshold when the direction select is clear.
// RULE6: Bit 5 sets when the configured byte count is sent while the direction select is set.
// RULE7: Bit 4 sets when a transmission starts with an empty transmit FIFO.
// RULE8: A transmit underflow raises the summary interrupt only while transmit flush is clear.
// RULE9: Bits 3:1 show the transmit FIFO fill as a binary count from 0 to 4.
// RULE10: Bit 0 sets on any port interrupt and clears when the status word is read.
// RULE11: Reading the status word clears the overflow, both interrupt and underflow flags.
// RULE12: Receive threshold codes 00 and 01 mean one byte, 10 three bytes, 11 four bytes.
// RULE13: While receive flush is set, incoming bytes raise no receive interrupt.
// RULE14: An event in the same cycle as the clearing read leaves its flag set.
// RULE15: Status bits 15 to 12 read as zero and ignore writes.
module spsf_top (
    // Bus clock domain
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Link clock domain
    input  wire logic                link_clk_i,
    input  wire logic                link_rst_i,
    input  wire spsf_pkg::spsf_link_s link_i,
    output spsf_pkg::spsf_ctrl_s     link_ctrl_o
);
    import spsf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: control bits arriving from the bus domain

    spsf_ctrl_s ctrl_q;
    spsf_ctrl_s ctrl_d;
    spsf_ctrl_s lctrl;

    // Control is quasi-static, so a plain two-stage crossing per bit is enough
    spsf_sync #(
        .WIDTH ($bits(spsf_ctrl_s))
    ) u_ctrl_sync (
        .clk_i (link_clk_i),
        .d_i   (ctrl_q),
        .q_o   (lctrl)
    );

    assign link_ctrl_o = lctrl;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: event detection, byte counting and fill encoding

    logic [3:0] ltog_q;
    logic [3:0] ltog_d;
    logic [2:0] ltxcnt_q;
    logic [2:0] ltxcnt_d;
    logic [2:0] lrxg_q;
    logic [2:0] lrxg_d;
    logic [2:0] ltxg_q;
    logic [2:0] ltxg_d;
    spsf_evt_s  levt;

    always_comb begin
        levt        = '0;
        ltxcnt_d    = ltxcnt_q;
        // Overflow: a load while four bytes are already present
        levt.ovf    = link_i.rx_load && (link_i.rx_fill_count == FILL_FULL); // see RULE3
        // Underflow: a start with nothing valid to send
        levt.uf     = link_i.tx_start && (link_i.tx_fill_count == FILL_EMPTY); // see RULE7
        // Receive interrupt once the fill after this load meets the threshold
        levt.rx_irq = link_i.rx_load
                      && !lctrl.transfer_direction_select // see RULE5
                      && !lctrl.rx_flush_control // see RULE13
                      && ((link_i.rx_fill_count == FILL_FULL)
                          || (3'(link_i.rx_fill_count + 3'h1)
                              >= rx_thr_bytes(lctrl.rx_threshold_field))); // see RULE12
        // Transmit interrupt after irq_threshold_field + 1 bytes have gone out
        if (link_i.tx_done && lctrl.transfer_direction_select) begin
            if (ltxcnt_q == {1'b0, lctrl.irq_threshold_field}) begin
                levt.tx_irq = 1'b1; // see RULE6
                ltxcnt_d    = 3'h0;
            end else begin
                ltxcnt_d    = 3'(ltxcnt_q + 3'h1);
            end
        end else if (!lctrl.transfer_direction_select) begin
            ltxcnt_d = 3'h0;
        end
        // Each event flips its toggle; the bus side sees every flip as one event
        ltog_d = ltog_q ^ {levt.ovf, levt.uf, levt.rx_irq, levt.tx_irq};
        // Fill levels leave this domain gray coded so a crossing sees one step
        lrxg_d = bin2gray(link_i.rx_fill_count);
        ltxg_d = bin2gray(link_i.tx_fill_count);
    end

    always_ff @(posedge link_clk_i) begin
        if (link_rst_i) begin
            ltog_q   <= 4'h0;
            ltxcnt_q <= 3'h0;
            lrxg_q   <= 3'h0;
            ltxg_q   <= 3'h0;
        end else begin
            ltog_q   <= ltog_d;
            ltxcnt_q <= ltxcnt_d;
            lrxg_q   <= lrxg_d;
            ltxg_q   <= ltxg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus domain: crossings from the link

    logic [3:0] btog;
    logic [2:0] brxg;
    logic [2:0] btxg;

    spsf_sync #(
        .WIDTH (10)
    ) u_link_sync (
        .clk_i (clk_i),
        .d_i   ({ltog_q, lrxg_q, ltxg_q}),
        .q_o   ({btog, brxg, btxg})
    );

    logic [3:0] btog_q;
    logic [3:0] btog_d;
    logic [2:0] rx_fill_q;
    logic [2:0] rx_fill_d;
    logic [2:0] tx_fill_q;
    logic [2:0] tx_fill_d;
    spsf_evt_s  bevt;

    always_comb begin
        btog_d    = btog;
        bevt      = spsf_evt_s'(btog ^ btog_q);
        rx_fill_d = gray2bin(brxg); // see RULE2
        tx_fill_d = gray2bin(btxg); // see RULE9
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            btog_q    <= 4'h0;
            rx_fill_q <= 3'h0;
            tx_fill_q <= 3'h0;
        end else begin
            btog_q    <= btog_d;
            rx_fill_q <= rx_fill_d;
            tx_fill_q <= tx_fill_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus domain: Wishbone slave and status flags

    logic        ack_q;
    logic        ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic        ovf_q;
    logic        ovf_d;
    logic        rxirq_q;
    logic        rxirq_d;
    logic        txirq_q;
    logic        txirq_d;
    logic        uf_q;
    logic        uf_d;
    logic        sum_q;
    logic        sum_d;
    logic        excess_q;
    logic        excess_d;
    logic        take;
    logic        st_read;
    logic        irq_evt;
    logic [15:0] status;

    always_comb begin
        // A request is taken once; ack drops the cycle after it was given
        take    = wb_cyc_i && wb_stb_i && !ack_q;
        st_read = take && !wb_we_i && (wb_adr_i == STATUS_OFS);
        ack_d   = take;
        ctrl_d  = ctrl_q;
        dat_d   = dat_q;

        // Summary interrupt sources; flush bits mask the error interrupts
        irq_evt = (bevt.ovf && !ctrl_q.rx_flush_control) // see RULE4
                  || (bevt.uf && !ctrl_q.tx_flush_control) // see RULE8
                  || bevt.rx_irq
                  || bevt.tx_irq;

        // Set wins over the read that clears
        ovf_d   = bevt.ovf    || (ovf_q   && !st_read); // see RULE11 RULE14
        rxirq_d = bevt.rx_irq || (rxirq_q && !st_read); // see RULE11 RULE14
        txirq_d = bevt.tx_irq || (txirq_q && !st_read); // see RULE11 RULE14
        uf_d    = bevt.uf     || (uf_q    && !st_read); // see RULE11 RULE14
        sum_d   = irq_evt     || (sum_q   && !st_read); // see RULE10 RULE14

        // Strictly more bytes present than the threshold asks for
        excess_d = rx_fill_q > rx_thr_bytes(ctrl_q.rx_threshold_field); // see RULE1

        status = 16'h0000; // see RULE15
        status[ST_EXCESS_BIT]                    = excess_q;
        status[ST_RXFILL_LSB +: FILL_W]          = rx_fill_q;
        status[ST_OVF_BIT]                       = ovf_q;
        status[ST_RXIRQ_BIT]                     = rxirq_q;
        status[ST_TXIRQ_BIT]                     = txirq_q;
        status[ST_UF_BIT]                        = uf_q;
        status[ST_TXFILL_LSB +: FILL_W]          = tx_fill_q;
        status[ST_SUM_BIT]                       = sum_q;

        if (take) begin
            dat_d = 32'h0000_0000;
            if (!wb_we_i) begin
                if (wb_adr_i == STATUS_OFS) begin
                    dat_d = {16'h0000, status};
                end else if (wb_adr_i == CONTROL_OFS) begin
                    dat_d = {25'h0000000, ctrl_q};
                end
            end else if ((wb_adr_i == CONTROL_OFS) && wb_sel_i[0]) begin
                ctrl_d = spsf_ctrl_s'(wb_dat_i[6:0]);
            end
            // Writes to the status word and to unmapped words are acked and dropped
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q    <= 1'b0;
            dat_q    <= 32'h0000_0000;
            ctrl_q   <= spsf_ctrl_s'(CONTROL_RESET);
            ovf_q    <= 1'b0;
            rxirq_q  <= 1'b0;
            txirq_q  <= 1'b0;
            uf_q     <= 1'b0;
            sum_q    <= 1'b0;
            excess_q <= 1'b0;
        end else begin
            ack_q    <= ack_d;
            dat_q    <= dat_d;
            ctrl_q   <= ctrl_d;
            ovf_q    <= ovf_d;
            rxirq_q  <= rxirq_d;
            txirq_q  <= txirq_d;
            uf_q     <= uf_d;
            sum_q    <= sum_d;
            excess_q <= excess_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

endmodule : spsf_top

// file: verif/spsf_assertions.sv
// Checker for the status-flag block, bound to the top module's ports.
// Assumes every assertion is judged in the bus clock domain.
module spsf_assertions
    import spsf_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [3:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic       wb_ack_o,
    input  wire logic       link_clk_i,
    input  wire logic       link_rst_i,
    input  wire spsf_link_s link_i,
    input  wire spsf_ctrl_s link_ctrl_o
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Address is still held by the master in the ack cycle
    sequence s_st_ans;
        wb_ack_o && !wb_we_i && wb_adr_i == STATUS_OFS;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    chk_ack_next: assert property (s_take |=> wb_ack_o)
        else $error("ack missing after a taken request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_status_hi_zero: assert property (s_st_ans |-> wb_dat_o[31:12] == 20'h0)
        else $error("status upper bits not zero");
    chk_rx_fill_range: assert property (s_st_ans |-> wb_dat_o[10:8] <= FILL_FULL)
        else $error("receive fill out of range");
    chk_tx_fill_range: assert property (s_st_ans |-> wb_dat_o[3:1] <= FILL_FULL)
        else $error("transmit fill out of range");
    chk_sum_cause: assert property (s_st_ans ##0 wb_dat_o[0] |-> |wb_dat_o[7:4])
        else $error("summary bit without a flag");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i != STATUS_OFS
        && wb_adr_i != CONTROL_OFS |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_dat_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data moved while idle");
endmodule : spsf_assertions

// file: verif/spsf_link_model.sv
// Model of the serial port's FIFO and shift logic on the link clock.
// Assumes callers change each fill count by at most one per step.
module spsf_link_model
    import spsf_pkg::*;
(
    input  wire logic link_clk_i,
    output spsf_link_s link_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial link_o = '0;

    ////////////////////////////////////////////////////////////////////////////
    // Pulses see the old fill; new fill lands a link cycle later, as a real FIFO
    task automatic step(input logic [2:0] p, input logic [2:0] r, input logic [2:0] t);
        @(posedge link_clk_i);
        {link_o.rx_load, link_o.tx_start, link_o.tx_done} <= p;
        @(posedge link_clk_i);
        {link_o.rx_load, link_o.tx_start, link_o.tx_done} <= 3'h0;
        link_o.rx_fill_count <= r;
        link_o.tx_fill_count <= t;
    endtask : step
endmodule : spsf_link_model

// file: verif/spsf_top_tb.sv
// Self-checking bench: Wishbone tasks, link events from the partner model.
// Assumes the 100 MHz bus clock and a 64 ns link clock unrelated in phase.
module spsf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spsf_pkg::*;

    logic        clk_i = 1'b0, rst_i = 1'b1, link_clk_i = 1'b0, link_rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [2:0]  rf = 3'h0, tf = 3'h0;
    spsf_link_s  link_i;
    spsf_ctrl_s  link_ctrl_o;
    int          failures = 0, check_count = 0;

    always #5 clk_i = ~clk_i;
    always #32 link_clk_i = ~link_clk_i;

    spsf_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk_i(link_clk_i),
        .link_rst_i(link_rst_i), .link_i(link_i), .link_ctrl_o(link_ctrl_o));
    spsf_link_model u_link (.link_clk_i(link_clk_i), .link_o(link_i));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, adr, 4'hF, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            tally_and_finish();
        end else begin
            rd = wb_dat_o;
            {wb_cyc_i, wb_stb_i} <= 2'h0;
        end
    endtask : wb
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rdc
    // Extra link cycles let a fresh control word reach the link side first
    task automatic ev(input logic [2:0] p, input logic [2:0] r, input logic [2:0] t);
        repeat (3) @(posedge link_clk_i);
        u_link.step(p, r, t);
        rf = r;
        tf = t;
        repeat (12) @(posedge clk_i);
    endtask : ev
    function automatic logic [31:0] sw(input logic ex, input logic [3:0] fl, input logic sm);
        return {20'h0, ex, rf, fl, tf, sm};
    endfunction : sw
    function automatic int thr(input int c);
        return (c == 3) ? 4 : (c == 2) ? 3 : 1;
    endfunction : thr

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge link_clk_i);
        link_rst_i <= 1'b0;
        repeat (4) @(posedge link_clk_i);
        // Bus reset again: its crossings carried unknowns until the first link clock edge reset the link side
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(STATUS_OFS, 32'h0);
        rdc(CONTROL_OFS, 32'h0);
        rdc(4'h8, 32'h0);
        wb(1'b1, STATUS_OFS, 32'hFFFF);
        rdc(STATUS_OFS, 32'h0);
        wb(1'b1, CONTROL_OFS, 32'h08);
        for (int i = 1; i <= 3; i++) begin
            ev(3'h4, i[2:0], 3'h0);
            rdc(STATUS_OFS, sw(1'b0, {1'b0, i == 3, 2'h0}, i == 3));
        end
        wb(1'b1, CONTROL_OFS, 32'h28);
        ev(3'h4, 3'h4, 3'h0);
        rdc(STATUS_OFS, sw(1'b1, 4'h0, 1'b0));
        wb(1'b1, CONTROL_OFS, 32'h1C);
        rdc(CONTROL_OFS, 32'h1C);
        ev(3'h4, 3'h4, 3'h0);
        rdc(STATUS_OFS, sw(1'b0, 4'h8, 1'b1));
        rdc(STATUS_OFS, sw(1'b0, 4'h0, 1'b0));
        wb(1'b1, CONTROL_OFS, 32'h3C);
        ev(3'h4, 3'h4, 3'h0);
        check(32'(link_ctrl_o), 32'h3C);
        rdc(STATUS_OFS, sw(1'b0, 4'h8, 1'b0));
        wb(1'b1, CONTROL_OFS, 32'h1C);
        ev(3'h2, 3'h4, 3'h0);
        rdc(STATUS_OFS, sw(1'b0, 4'h1, 1'b1));
        wb(1'b1, CONTROL_OFS, 32'h5C);
        ev(3'h2, 3'h4, 3'h0);
        rdc(STATUS_OFS, sw(1'b0, 4'h1, 1'b0));
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, CONTROL_OFS, 32'h1C | 32'(m));
            repeat (m) ev(3'h1, 3'h4, 3'h0);
            rdc(STATUS_OFS, sw(1'b0, 4'h0, 1'b0));
            ev(3'h1, 3'h4, 3'h0);
            rdc(STATUS_OFS, sw(1'b0, 4'h2, 1'b1));
        end
        wb(1'b1, CONTROL_OFS, 32'h0C);
        ev(3'h1, 3'h4, 3'h0);
        rdc(STATUS_OFS, sw(1'b0, 4'h0, 1'b0));
        // Fill ramp: receive side drains while transmit side fills
        for (int f = 4; f >= 0; f--) begin
            if (f < 4) begin
                ev(3'h0, f[2:0], 3'(4 - f));
            end
            for (int c = 0; c < 4; c++) begin
                wb(1'b1, CONTROL_OFS, 32'h10 | 32'(c << 2));
                repeat (12) @(posedge clk_i);
                rdc(STATUS_OFS, sw(f > thr(c), 4'h0, 1'b0));
            end
        end
        ev(3'h2, 3'h0, 3'h4);
        rdc(STATUS_OFS, sw(1'b0, 4'h0, 1'b0));
        tally_and_finish();
    end
endmodule : spsf_top_tb

bind spsf_top spsf_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk_i(link_clk_i),
    .link_rst_i(link_rst_i), .link_i(link_i), .link_ctrl_o(link_ctrl_o));
